// ### rtl/bpwr_regs.sv
// Prefetch window register bank of the bridge function
//
// How it works
// - Bit 0 of the low bound register holds the width capability, reset 1.
// - Bits 15:4 of the low bound register hold base A[31:20], reset fff.
// - Bits 15:4 of the high bound register hold limit A[31:20], reset 0.
// - Bit 0 of the high bound register reads back the capability flag.
// - Base, limit and, with capability 1, upper halves decide which addresses are forwarded.
// - A 32-bit upper base register resets to all ones.
// - A 32-bit upper limit register resets to zero.
// - With capability 0 both upper registers read zero and ignore writes.
// - A 16-bit upper I/O base register resets to all ones.
// - With I/O capability 0 the upper I/O base reads zero, ignores writes.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
module bpwr_regs (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [63:0] PROBE_ADDR,
  input wire logic PROBE_VALID,
  output logic FWD_HIT,
  output logic FWD_VALID,
  output logic [63:0] WIN_BASE,
  output logic [63:0] WIN_LIMIT
);
  import bpwr_pkg::*;

  bpwr_req_t req;
  bpwr_regs_t st_r;
  bpwr_regs_t st_nxt;
  logic prep;
  logic accept;
  logic win_open;
  logic hit_seen;
  logic [31:0] wlow;
  logic [31:0] rd_val;

  // Merge write data into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = m;
  endfunction : merge

  // Bus pins gathered into one request
  always_comb
  begin
    req.rd = AVS_READ;
    req.wr = AVS_WRITE;
    req.idx = AVS_ADDRESS;
    req.wdata = AVS_WRITEDATA;
    req.be = AVS_BYTEENABLE;
  end

  // Bus handshake: one wait cycle, then the answer
  bpwr_avs u_avs (
    .clk(CORE_CLK),
    .nrst(NRST),
    .req(req),
    .waitrequest(AVS_WAITREQUEST),
    .prep(prep),
    .accept(accept)
  );

  // Window bounds and forwarding decision
  bpwr_win u_win (
    .clk(CORE_CLK),
    .nrst(NRST),
    .pref_cap(st_r.pref_cap),
    .low_bound(st_r.low_bound),
    .high_bound(st_r.high_bound),
    .low_upper(st_r.low_upper),
    .high_upper(st_r.high_upper),
    .probe_addr(PROBE_ADDR),
    .probe_valid(PROBE_VALID),
    .win_open(win_open),
    .win_base(WIN_BASE),
    .win_limit(WIN_LIMIT),
    .fwd_hit(FWD_HIT),
    .fwd_valid(FWD_VALID)
  );

  assign hit_seen = FWD_HIT;

  // Read value of the addressed register
  always_comb
  begin
    rd_val = 32'h00000000;
    case (req.idx)
      IDX_PREF_BASE_LOW:
      begin
        rd_val[BOUND_MSB:BOUND_LSB] = st_r.low_bound;
        rd_val[CAP_BIT] = st_r.pref_cap;
      end
      IDX_PREF_LIMIT_LOW:
      begin
        rd_val[BOUND_MSB:BOUND_LSB] = st_r.high_bound;
        rd_val[CAP_BIT] = st_r.pref_cap;
      end
      IDX_PREF_BASE_HIGH:
      begin
        if (st_r.pref_cap)
          rd_val = st_r.low_upper;
      end
      IDX_PREF_LIMIT_HIGH:
      begin
        if (st_r.pref_cap)
          rd_val = st_r.high_upper;
      end
      IDX_IO_BASE_HIGH:
      begin
        if (st_r.io_cap)
          rd_val[15:0] = st_r.io_upper;
      end
      IDX_CTRL:
      begin
        rd_val[CTRL_IO_CAP_BIT] = st_r.io_cap;
        rd_val[CTRL_CAP_LOCK_BIT] = st_r.cap_lock;
      end
      IDX_STAT:
      begin
        rd_val[STAT_OPEN_BIT] = win_open;
        rd_val[STAT_HIT_BIT] = hit_seen;
      end
      default:
        rd_val = 32'h00000000;
    endcase
  end

  // Register updates at the accept edge, read data at the prep edge
  always_comb
  begin
    st_nxt = st_r;
    wlow = {16'h0000, st_r.high_bound, 4'h0};
    if (prep && req.rd)
      st_nxt.rdata = rd_val;
    if (accept && req.wr)
    begin
      case (req.idx)
        IDX_PREF_BASE_LOW:
        begin
          wlow = merge({16'h0000, st_r.low_bound, 3'h0, st_r.pref_cap},
                       req.wdata, req.be);
          st_nxt.low_bound = wlow[BOUND_MSB:BOUND_LSB];
          if (!st_r.cap_lock)
            st_nxt.pref_cap = wlow[CAP_BIT];
        end
        IDX_PREF_LIMIT_LOW:
        begin
          wlow = merge({16'h0000, st_r.high_bound, 4'h0},
                       req.wdata, req.be);
          st_nxt.high_bound = wlow[BOUND_MSB:BOUND_LSB];
        end
        IDX_PREF_BASE_HIGH:
        begin
          if (st_r.pref_cap)
            st_nxt.low_upper = merge(st_r.low_upper, req.wdata,
                                     req.be);
        end
        IDX_PREF_LIMIT_HIGH:
        begin
          if (st_r.pref_cap)
            st_nxt.high_upper = merge(st_r.high_upper, req.wdata,
                                      req.be);
        end
        IDX_IO_BASE_HIGH:
        begin
          if (st_r.io_cap)
          begin
            wlow = merge({16'h0000, st_r.io_upper}, req.wdata, req.be);
            st_nxt.io_upper = wlow[15:0];
          end
        end
        IDX_CTRL:
        begin
          if (req.be[0])
          begin
            st_nxt.io_cap = req.wdata[CTRL_IO_CAP_BIT];
            st_nxt.cap_lock = req.wdata[CTRL_CAP_LOCK_BIT];
          end
        end
        default:
          st_nxt.rdata = st_r.rdata;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      st_r <= REGS_RST;
    else
      st_r <= st_nxt;
  end

  assign AVS_READDATA = st_r.rdata;

  // Checks on the bank
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  property p_cap_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.pref_cap == RST_PREF_CAP;
  endproperty
  a_cap_reset: assert property (p_cap_reset)
    else $error("capability flag not set after reset");

  property p_base_write;
    accept && req.wr && req.idx == IDX_PREF_BASE_LOW && req.be[1:0] == 2'h3
    |=> st_r.low_bound == $past(req.wdata[BOUND_MSB:BOUND_LSB]);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("low bound write not stored");

  property p_limit_write;
    accept && req.wr && req.idx == IDX_PREF_LIMIT_LOW
    && req.be[1:0] == 2'h3
    |=> st_r.high_bound == $past(req.wdata[BOUND_MSB:BOUND_LSB]);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("high bound write not stored");

  property p_cap_mirror;
    prep && req.rd && req.idx == IDX_PREF_LIMIT_LOW
    |=> AVS_READDATA[CAP_BIT] == st_r.pref_cap && !AVS_WAITREQUEST;
  endproperty
  a_cap_mirror: assert property (p_cap_mirror)
    else $error("high bound read lacks capability copy");

  property p_fwd_valid;
    PROBE_VALID |=> FWD_VALID;
  endproperty
  a_fwd_valid: assert property (p_fwd_valid)
    else $error("probe not answered next cycle");

  property p_upper_write;
    accept && req.wr && req.idx == IDX_PREF_BASE_HIGH && st_r.pref_cap
    && req.be == 4'hf |=> st_r.low_upper == $past(req.wdata);
  endproperty
  a_upper_write: assert property (p_upper_write)
    else $error("upper base write not stored");

  property p_limit_upper_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.high_upper == RST_HIGH_UPPER;
  endproperty
  a_limit_upper_reset: assert property (p_limit_upper_reset)
    else $error("upper limit not zero after reset");

  property p_upper_locked;
    accept && req.wr && req.idx == IDX_PREF_BASE_HIGH && !st_r.pref_cap
    |=> $stable(st_r.low_upper);
  endproperty
  a_upper_locked: assert property (p_upper_locked)
    else $error("upper base written under narrow addressing");

  property p_io_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.io_upper == RST_IO_UPPER;
  endproperty
  a_io_reset: assert property (p_io_reset)
    else $error("upper I/O base not all ones after reset");

  property p_io_hidden;
    prep && req.rd && req.idx == IDX_IO_BASE_HIGH && !st_r.io_cap
    |=> AVS_READDATA == 32'h00000000;
  endproperty
  a_io_hidden: assert property (p_io_hidden)
    else $error("upper I/O base visible without I/O capability");

  property p_no_hit_closed;
    FWD_HIT |-> $past(win_open);
  endproperty
  a_no_hit_closed: assert property (p_no_hit_closed)
    else $error("hit reported through an inverted window");

  property p_hit_inside;
    FWD_HIT |-> $past(PROBE_ADDR) >= WIN_BASE
    && $past(PROBE_ADDR) <= WIN_LIMIT;
  endproperty
  a_hit_inside: assert property (p_hit_inside)
    else $error("hit reported for an address outside the window");

  property p_cap_locked;
    accept && req.wr && req.idx == IDX_PREF_BASE_LOW && st_r.cap_lock
    |=> $stable(st_r.pref_cap);
  endproperty
  a_cap_locked: assert property (p_cap_locked)
    else $error("capability flag changed while locked");

  property p_base_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.low_bound == RST_LOW_BOUND;
  endproperty
  a_base_reset: assert property (p_base_reset)
    else $error("low bound not all ones after reset");

  property p_limit_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.high_bound == RST_HIGH_BOUND;
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("high bound not zero after reset");

  property p_upper_reset;
    @(posedge CORE_CLK) disable iff (1'b0)
    !NRST |=> st_r.low_upper == RST_LOW_UPPER;
  endproperty
  a_upper_reset: assert property (p_upper_reset)
    else $error("upper base not all ones after reset");

  property p_limit_upper_locked;
    accept && req.wr && req.idx == IDX_PREF_LIMIT_HIGH && !st_r.pref_cap
    |=> $stable(st_r.high_upper);
  endproperty
  a_limit_upper_locked: assert property (p_limit_upper_locked)
    else $error("upper limit written under narrow addressing");

  property p_limit_hidden;
    prep && req.rd && req.idx == IDX_PREF_LIMIT_HIGH && !st_r.pref_cap
    |=> AVS_READDATA == 32'h00000000;
  endproperty
  a_limit_hidden: assert property (p_limit_hidden)
    else $error("upper limit visible under narrow addressing");

  property p_io_locked;
    accept && req.wr && req.idx == IDX_IO_BASE_HIGH && !st_r.io_cap
    |=> $stable(st_r.io_upper);
  endproperty
  a_io_locked: assert property (p_io_locked)
    else $error("upper I/O base written without I/O capability");
endmodule : bpwr_regs

// ### rtl/bpwr_pkg.sv
// Shared constants and types of the prefetch window register bank
package bpwr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PREF_BASE_LOW = 8'h24;
  localparam logic [7:0] IDX_PREF_LIMIT_LOW = 8'h26;
  localparam logic [7:0] IDX_PREF_BASE_HIGH = 8'h28;
  localparam logic [7:0] IDX_PREF_LIMIT_HIGH = 8'h2c;
  localparam logic [7:0] IDX_IO_BASE_HIGH = 8'h30;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_STAT = 8'h41;
  // Field positions
  localparam int CAP_BIT = 0;
  localparam int BOUND_LSB = 4;
  localparam int BOUND_MSB = 15;
  localparam int CTRL_IO_CAP_BIT = 0;
  localparam int CTRL_CAP_LOCK_BIT = 1;
  localparam int STAT_OPEN_BIT = 0;
  localparam int STAT_HIT_BIT = 1;
  // Window granule: 1MB
  localparam int GRAN_BITS = 20;
  localparam logic [19:0] GRAN_ONES = 20'hfffff;
  // Reset values
  localparam logic RST_PREF_CAP = 1'b1;
  localparam logic [11:0] RST_LOW_BOUND = 12'hfff;
  localparam logic [11:0] RST_HIGH_BOUND = 12'h000;
  localparam logic [31:0] RST_LOW_UPPER = 32'hffffffff;
  localparam logic [31:0] RST_HIGH_UPPER = 32'h00000000;
  localparam logic [15:0] RST_IO_UPPER = 16'hffff;
  localparam logic RST_IO_CAP = 1'b1;
  localparam logic RST_CAP_LOCK = 1'b0;

  // One bus request as seen by the bank
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic [31:0] wdata;
    logic [3:0] be;
  } bpwr_req_t;

  // Register state of the bank
  typedef struct packed {
    logic pref_cap;
    logic [11:0] low_bound;
    logic [11:0] high_bound;
    logic [31:0] low_upper;
    logic [31:0] high_upper;
    logic [15:0] io_upper;
    logic io_cap;
    logic cap_lock;
    logic [31:0] rdata;
  } bpwr_regs_t;

  localparam bpwr_regs_t REGS_RST = '{
    pref_cap: RST_PREF_CAP, low_bound: RST_LOW_BOUND,
    high_bound: RST_HIGH_BOUND, low_upper: RST_LOW_UPPER,
    high_upper: RST_HIGH_UPPER, io_upper: RST_IO_UPPER,
    io_cap: RST_IO_CAP, cap_lock: RST_CAP_LOCK, rdata: 32'h00000000};
endpackage : bpwr_pkg

// ### rtl/bpwr_avs.sv
// Avalon-MM waitrequest handshake for the register bank
`timescale 1ns/1ns
module bpwr_avs (
  input wire logic clk,
  input wire logic nrst,
  input wire bpwr_pkg::bpwr_req_t req,
  output logic waitrequest,
  output logic prep,
  output logic accept
);
  import bpwr_pkg::*;

  typedef struct packed {
    logic wait_r;
  } bpwr_avs_st_t;

  bpwr_avs_st_t st_r;
  bpwr_avs_st_t st_nxt;
  logic active;

  // Prep edge drops waitrequest, accept edge completes the transfer
  always_comb
  begin
    active = req.rd | req.wr;
    prep = active & st_r.wait_r;
    accept = active & ~st_r.wait_r;
    st_nxt.wait_r = ~prep;
  end

  // Waitrequest rests high between transfers
  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_r <= '{wait_r: 1'b1};
    else
      st_r <= st_nxt;
  end

  assign waitrequest = st_r.wait_r;
endmodule : bpwr_avs

// ### rtl/bpwr_win.sv
// Prefetchable window bounds and forwarding decision
`timescale 1ns/1ns
module bpwr_win (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pref_cap,
  input wire logic [11:0] low_bound,
  input wire logic [11:0] high_bound,
  input wire logic [31:0] low_upper,
  input wire logic [31:0] high_upper,
  input wire logic [63:0] probe_addr,
  input wire logic probe_valid,
  output logic win_open,
  output logic [63:0] win_base,
  output logic [63:0] win_limit,
  output logic fwd_hit,
  output logic fwd_valid
);
  import bpwr_pkg::*;

  typedef struct packed {
    logic [63:0] base;
    logic [63:0] limit;
    logic hit;
    logic valid;
  } bpwr_win_st_t;

  bpwr_win_st_t st_r;
  bpwr_win_st_t st_nxt;
  logic [63:0] base_c;
  logic [63:0] limit_c;

  // Inclusive range test; an inverted window holds nothing
  function automatic logic in_win(input logic [63:0] a,
                                  input logic [63:0] b,
                                  input logic [63:0] l);
    in_win = (b <= l) && (a >= b) && (a <= l);
  endfunction : in_win

  // Upper halves count as zero under narrow addressing
  always_comb
  begin
    base_c = {pref_cap ? low_upper : 32'h00000000, low_bound,
              {GRAN_BITS{1'b0}}};
    limit_c = {pref_cap ? high_upper : 32'h00000000, high_bound,
               GRAN_ONES};
    win_open = base_c <= limit_c;
    st_nxt.base = base_c;
    st_nxt.limit = limit_c;
    st_nxt.hit = probe_valid && in_win(probe_addr, base_c, limit_c);
    st_nxt.valid = probe_valid;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_r <= '{base: 64'h0, limit: 64'h0, hit: 1'b0, valid: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign win_base = st_r.base;
  assign win_limit = st_r.limit;
  assign fwd_hit = st_r.hit;
  assign fwd_valid = st_r.valid;
endmodule : bpwr_win

// ### verification/tb.sv
// Self-checking bench of the prefetch window register bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    tests_run = tests_run + 1; \
    if ((got) !== (ex)) \
    begin \
      failures = failures + 1; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  import bpwr_pkg::*;
  logic core_clk;
  logic nrst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [63:0] probe_addr;
  logic probe_valid;
  logic fwd_hit;
  logic fwd_valid;
  logic [63:0] win_base;
  logic [63:0] win_limit;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 84429;
  logic [11:0] lb;
  logic [11:0] hb;
  logic [31:0] lu;
  logic [31:0] hu;
  logic cap;
  logic wo;

  bpwr_regs dut (.CORE_CLK(core_clk), .NRST(nrst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .PROBE_ADDR(probe_addr),
    .PROBE_VALID(probe_valid), .FWD_HIT(fwd_hit),
    .FWD_VALID(fwd_valid), .WIN_BASE(win_base), .WIN_LIMIT(win_limit));

  // Clock of 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 10000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  // Expected combined window bound
  function automatic logic [63:0] exp_bound(input logic c,
    input logic [31:0] u, input logic [11:0] f, input logic [19:0] lo);
    return {c ? u : 32'h00000000, f, lo};
  endfunction : exp_bound

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic avs_xfer(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= idx;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs_xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
    input logic [3:0] be);
    logic [31:0] r;
    avs_xfer(1'b1, idx, d, be, r);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx,
    input logic [31:0] ex);
    logic [31:0] r;
    avs_xfer(1'b0, idx, 32'h00000000, 4'hf, r);
    `CHK(nm, ex, r)
  endtask : rd_chk

  // Single probe, answer one cycle after it is taken
  task automatic probe_chk(input logic [63:0] a, input logic [63:0] b,
    input logic [63:0] l);
    @(posedge core_clk);
    probe_valid <= 1'b1;
    probe_addr <= a;
    @(posedge core_clk);
    probe_valid <= 1'b0;
    @(posedge core_clk);
    `CHK("fwd_valid", 1'b1, fwd_valid)
    `CHK("fwd_hit", (b <= a) && (a <= l), fwd_hit)
  endtask : probe_chk

  // Bounds on the ports and probes at the window edges
  task automatic win_test;
    logic [63:0] b;
    logic [63:0] l;
    b = exp_bound(cap, lu, lb, 20'h00000);
    l = exp_bound(cap, hu, hb, 20'hfffff);
    repeat (3) @(posedge core_clk);
    `CHK("win_base", b, win_base)
    `CHK("win_limit", l, win_limit)
    probe_chk(b, b, l);
    probe_chk(b - 64'h1, b, l);
    probe_chk(l, b, l);
    probe_chk(l + 64'h1, b, l);
    probe_chk({b[63:32], 32'($random(seed))}, b, l);
  endtask : win_test

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : do_reset

  // Reset values and the empty window they give
  task automatic chk_rst;
    rd_chk("base_low", IDX_PREF_BASE_LOW, 32'h0000fff1);
    rd_chk("limit_low", IDX_PREF_LIMIT_LOW, 32'h00000001);
    rd_chk("base_high", IDX_PREF_BASE_HIGH, 32'hffffffff);
    rd_chk("limit_high", IDX_PREF_LIMIT_HIGH, 32'h00000000);
    rd_chk("io_high", IDX_IO_BASE_HIGH, 32'h0000ffff);
    rd_chk("status", IDX_STAT, 32'h00000000);
    cap = 1'b1;
    lb = 12'hfff;
    hb = 12'h000;
    lu = 32'hffffffff;
    hu = 32'h00000000;
    win_test();
  endtask : chk_rst

  initial
  begin
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    probe_addr = 64'h0;
    probe_valid = 1'b0;
    do_reset();
    chk_rst();
    // Unmapped place keeps nothing
    wr(8'h10, 32'hffffffff, 4'hf);
    rd_chk("unmapped", 8'h10, 32'h00000000);
    // Random windows, every fourth one narrow
    for (int i = 0; i < 24; i++)
    begin
      lb = 12'($random(seed));
      hb = 12'($random(seed));
      lu = $random(seed);
      hu = i[0] ? lu : lu + 32'($random(seed) & 3);
      cap = (i % 4) != 3;
      wr(IDX_PREF_BASE_LOW, {16'h0000, lb, 3'h0, cap}, 4'hf);
      wr(IDX_PREF_LIMIT_LOW, {16'h0000, hb, 4'h0}, 4'hf);
      wr(IDX_PREF_BASE_HIGH, lu, 4'hf);
      wr(IDX_PREF_LIMIT_HIGH, hu, 4'hf);
      rd_chk("base_low", IDX_PREF_BASE_LOW, {lb, 3'h0, cap});
      rd_chk("limit_low", IDX_PREF_LIMIT_LOW, {hb, 3'h0, cap});
      rd_chk("base_high", IDX_PREF_BASE_HIGH, cap ? lu : 0);
      rd_chk("limit_high", IDX_PREF_LIMIT_HIGH, cap ? hu : 0);
      wo = exp_bound(cap, lu, lb, 20'h00000)
        <= exp_bound(cap, hu, hb, 20'hfffff);
      rd_chk("status", IDX_STAT, {31'h0, wo});
      win_test();
    end
    // Hidden upper half ignores writes and reappears
    wr(IDX_PREF_BASE_LOW, 32'h00000001, 4'hf);
    wr(IDX_PREF_LIMIT_HIGH, 32'h13572468, 4'hf);
    wr(IDX_PREF_BASE_HIGH, 32'h12345678, 4'hf);
    wr(IDX_PREF_BASE_HIGH, 32'h000000aa, 4'h1);
    rd_chk("base_high", IDX_PREF_BASE_HIGH, 32'h123456aa);
    wr(IDX_PREF_BASE_LOW, 32'h00000000, 4'hf);
    wr(IDX_PREF_BASE_HIGH, 32'hdeadbeef, 4'hf);
    wr(IDX_PREF_LIMIT_HIGH, 32'hdeadbeef, 4'hf);
    rd_chk("base_high", IDX_PREF_BASE_HIGH, 32'h00000000);
    wr(IDX_PREF_BASE_LOW, 32'h00000001, 4'hf);
    rd_chk("base_high", IDX_PREF_BASE_HIGH, 32'h123456aa);
    rd_chk("limit_high", IDX_PREF_LIMIT_HIGH, 32'h13572468);
    // Upper I/O base and its capability flag
    wr(IDX_IO_BASE_HIGH, 32'h0000a5a5, 4'hf);
    rd_chk("io_high", IDX_IO_BASE_HIGH, 32'h0000a5a5);
    wr(IDX_CTRL, 32'h00000000, 4'hf);
    wr(IDX_IO_BASE_HIGH, 32'h00001234, 4'hf);
    rd_chk("io_high", IDX_IO_BASE_HIGH, 32'h00000000);
    wr(IDX_CTRL, 32'h00000001, 4'hf);
    rd_chk("io_high", IDX_IO_BASE_HIGH, 32'h0000a5a5);
    // Locked capability bit ignores writes
    wr(IDX_CTRL, 32'h00000003, 4'hf);
    wr(IDX_PREF_BASE_LOW, 32'h00000000, 4'hf);
    rd_chk("base_low", IDX_PREF_BASE_LOW, 32'h00000001);
    rd_chk("ctrl", IDX_CTRL, 32'h00000003);
    wr(IDX_CTRL, 32'h00000001, 4'hf);
    // Second reset restores every value
    do_reset();
    chk_rst();
    tally_and_finish();
  end
endmodule : tb
